/* core/pllcg_cfg.svh */
`ifndef PLLCG_CFG_SVH
`define PLLCG_CFG_SVH

// register byte offsets
`define PLLCG_OFS_CSR     6'h00
`define PLLCG_OFS_MULT    6'h04
`define PLLCG_OFS_PRE     6'h08
`define PLLCG_OFS_CORE    6'h0c
`define PLLCG_OFS_PBUS    6'h10
`define PLLCG_OFS_MEM     6'h14
`define PLLCG_OFS_OSC     6'h18
`define PLLCG_OFS_GBL     6'h1c
`define PLLCG_OFS_DEVICE_CONFIGURATION_REGISTER  6'h20

// field positions
`define PLLCG_PATH_BIT    0
`define PLLCG_PWRDN_BIT   1
`define PLLCG_RSTC_BIT    3
`define PLLCG_STABLE_BIT  6
`define PLLCG_DIVEN_BIT   15
`define PLLCG_SECOND_CLOCK_OUT_ENABLE_BIT   3
`define PLLCG_MEMEN_BIT   5
`define PLLCG_MSRC_BIT    4
`define PLLCG_RATIO_W     5

// writable masks
`define PLLCG_MSK_CSR     32'h0000000b
`define PLLCG_MSK_MULT    32'h0000001f
`define PLLCG_MSK_DIV     32'h0000801f
`define PLLCG_MSK_GBL     32'h00000028
`define PLLCG_MSK_DEVICE_CONFIGURATION_REGISTER  32'h00000010

// reset values
`define PLLCG_RST_CSR     32'h00000008
`define PLLCG_RST_MULT    32'h00000004
`define PLLCG_RST_PRE     32'h00008000
`define PLLCG_RST_CORE    32'h00008000
`define PLLCG_RST_PBUS    32'h00008001
`define PLLCG_RST_MEM     32'h00008001
`define PLLCG_RST_OSC     32'h00008007
`define PLLCG_RST_GBL     32'h00000028
`define PLLCG_RST_DEVICE_CONFIGURATION_REGISTER  32'h00000000

// timing
`define PLLCG_CLK_HZ      10000000
`define PLLCG_RST_NS      125
`define PLLCG_RST_CYC     ((`PLLCG_RST_NS * `PLLCG_CLK_HZ + 999999999) / 1000000000)
`define PLLCG_STABLE_DEF  256
`define PLLCG_ACC_W       10

`endif

/* core/pllcg_pkg.sv */
package pllcg_pkg;
	typedef logic [4:0] pllcg_ratio_t;
	typedef enum logic [2:0]
	{
		PLLCG_DV_PRE  = 3'b000,
		PLLCG_DV_CORE = 3'b001,
		PLLCG_DV_PBUS = 3'b010,
		PLLCG_DV_MEM  = 3'b011,
		PLLCG_DV_OSC  = 3'b100
	} pllcg_div_id_t;
endpackage

/* core/pllcg_div_if.sv */
`timescale 1ns/1ps
interface pllcg_div_if;
	logic                  tick_in;
	logic                  en;
	pllcg_pkg::pllcg_ratio_t ratio;
	logic                  tick_out;
	modport ctl (output tick_in, output en, output ratio, input tick_out);
	modport div (input tick_in, input en, input ratio, output tick_out);
endinterface

/* core/pllcg_div.sv */
`timescale 1ns/1ps
module pllcg_div
(
	pllcg_div_if.div bus,
	input wire logic CLK,
	input wire logic RST
);
	pllcg_pkg::pllcg_ratio_t cnt_ff;
	pllcg_pkg::pllcg_ratio_t nxt_cnt;
	pllcg_pkg::pllcg_ratio_t ratio_ff;
	pllcg_pkg::pllcg_ratio_t nxt_ratio;
	logic                    out_ff;
	logic                    nxt_out;
	wire                     wrap;

	////////////////////////////////////////////////////////////////////
	// counts input ticks, one output tick per ratio+1 inputs
	assign wrap      = bus.tick_in && (cnt_ff == ratio_ff);
	assign nxt_cnt   = !bus.en ? '0 :
		wrap ? '0 : bus.tick_in ? cnt_ff + 5'h01 : cnt_ff;
	// new ratio only at a period boundary, no short pulses
	assign nxt_ratio = (!bus.en || wrap) ? bus.ratio : ratio_ff;
	assign nxt_out   = bus.en && wrap;
	assign bus.tick_out = out_ff;

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			cnt_ff   <= '0;
			ratio_ff <= '0;
			out_ff   <= 1'b0;
		end
		else
		begin
			cnt_ff   <= nxt_cnt;
			ratio_ff <= nxt_ratio;
			out_ff   <= nxt_out;
		end
	end
endmodule

/* core/pllcg_top.sv */
`timescale 1ns/1ps
`include "pllcg_cfg.svh"
module pllcg_top
#(
	parameter int STABLE_EDGES = `PLLCG_STABLE_DEF
)
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        REF_IN,
	input  wire logic        MEM_CLK_IN,
	input  wire logic [5:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             AUDIO_AUX_CLK,
	output logic             HF_REF_TICK,
	output logic             CORE_CLK,
	output logic             PBUS_CLK,
	output logic             MEM_IF_CLK,
	output logic             SECOND_CLK_OUT,
	output logic             THIRD_CLK_OUT,
	output logic             MEM_CLK_OUT
);
	////////////////////////////////////////////////////////////////////
	// byte-lane merge of a write into a register
	function automatic logic [31:0] wr_merge
	(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  be,
		input logic [31:0] msk
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r & msk;
	endfunction

	function automatic logic [31:0] wr_reg
	(
		input logic [31:0] old,
		input logic        hit,
		input logic [31:0] nw,
		input logic [3:0]  be,
		input logic [31:0] msk
	);
		return hit ? wr_merge(old, nw, be, msk) : old;
	endfunction

	////////////////////////////////////////////////////////////////////
	// registers
	logic [31:0] pll_control_status_register_ff;
	logic [31:0] pll_multiplier_register_ff;
	logic [31:0] input_prescaler_register_ff;
	logic [31:0] core_divider_register_ff;
	logic [31:0] peripheral_divider_register_ff;
	logic [31:0] memory_divider_register_ff;
	logic [31:0] oscillator_divider_register_ff;
	logic [31:0] memory_interface_global_control_ff;
	logic [31:0] device_configuration_register_ff;
	logic [31:0] readdata_ff;
	logic        wait_ff;
	logic        stable_ff;
	logic [15:0] stable_cnt_ff;
	logic        ref_q_ff;
	logic [`PLLCG_ACC_W-1:0] acc_ff;
	logic        pll_tick_ff;
	logic        aux_ff;
	logic        hf_ff;
	logic        core_ff;
	logic        pbus_ff;
	logic        memif_ff;
	logic        ck2_ff;
	logic        ck3_ff;
	logic        mout_ff;

	wire         req;
	wire         wr_go;
	wire         rd_load;
	wire         nxt_wait;
	wire [31:0]  rdata;
	wire         ref_edge;
	wire         pll_run;
	wire         path_pll;
	wire         hf_tick;
	wire         pre_tick;
	wire [`PLLCG_ACC_W-1:0] acc_add;
	wire [`PLLCG_ACC_W-1:0] nxt_acc;
	wire         nxt_pll_tick;
	wire         nxt_stable;
	wire [15:0]  nxt_stable_cnt;
	wire         nxt_ck2;
	wire         nxt_mout;
	wire         h_csr;
	wire         h_mult;
	wire         h_pre;
	wire         h_core;
	wire         h_pbus;
	wire         h_mem;
	wire         h_osc;
	wire         h_gbl;
	wire         h_dev;

	////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, then answer
	assign req      = AVS_READ || AVS_WRITE;
	assign nxt_wait = !(req && wait_ff);
	assign wr_go    = AVS_WRITE && !wait_ff;
	assign rd_load  = AVS_READ && wait_ff;

	assign h_csr  = wr_go && (AVS_ADDRESS == `PLLCG_OFS_CSR);
	assign h_mult = wr_go && (AVS_ADDRESS == `PLLCG_OFS_MULT);
	assign h_pre  = wr_go && (AVS_ADDRESS == `PLLCG_OFS_PRE);
	assign h_core = wr_go && (AVS_ADDRESS == `PLLCG_OFS_CORE);
	assign h_pbus = wr_go && (AVS_ADDRESS == `PLLCG_OFS_PBUS);
	assign h_mem  = wr_go && (AVS_ADDRESS == `PLLCG_OFS_MEM);
	assign h_osc  = wr_go && (AVS_ADDRESS == `PLLCG_OFS_OSC);
	assign h_gbl  = wr_go && (AVS_ADDRESS == `PLLCG_OFS_GBL);
	assign h_dev  = wr_go && (AVS_ADDRESS == `PLLCG_OFS_DEVICE_CONFIGURATION_REGISTER);

	assign rdata =
		(AVS_ADDRESS == `PLLCG_OFS_CSR) ? (pll_control_status_register_ff
			| ({31'h0, stable_ff} << `PLLCG_STABLE_BIT)) :
		(AVS_ADDRESS == `PLLCG_OFS_MULT)   ? pll_multiplier_register_ff :
		(AVS_ADDRESS == `PLLCG_OFS_PRE)    ? input_prescaler_register_ff :
		(AVS_ADDRESS == `PLLCG_OFS_CORE)   ? core_divider_register_ff :
		(AVS_ADDRESS == `PLLCG_OFS_PBUS)   ? peripheral_divider_register_ff :
		(AVS_ADDRESS == `PLLCG_OFS_MEM)    ? memory_divider_register_ff :
		(AVS_ADDRESS == `PLLCG_OFS_OSC)    ? oscillator_divider_register_ff :
		(AVS_ADDRESS == `PLLCG_OFS_GBL)  ? memory_interface_global_control_ff :
		(AVS_ADDRESS == `PLLCG_OFS_DEVICE_CONFIGURATION_REGISTER) ? device_configuration_register_ff :
		32'h00000000;

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			wait_ff     <= 1'b1;
			readdata_ff <= 32'h00000000;
		end
		else
		begin
			wait_ff <= nxt_wait;
			if (rd_load)
				readdata_ff <= rdata;
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			pll_control_status_register_ff <= `PLLCG_RST_CSR;
			pll_multiplier_register_ff     <= `PLLCG_RST_MULT;
			input_prescaler_register_ff    <= `PLLCG_RST_PRE;
			core_divider_register_ff       <= `PLLCG_RST_CORE;
			peripheral_divider_register_ff <= `PLLCG_RST_PBUS;
			memory_divider_register_ff     <= `PLLCG_RST_MEM;
			oscillator_divider_register_ff <= `PLLCG_RST_OSC;
			memory_interface_global_control_ff <= `PLLCG_RST_GBL;
			device_configuration_register_ff   <= `PLLCG_RST_DEVICE_CONFIGURATION_REGISTER;
		end
		else
		begin
			pll_control_status_register_ff <= wr_reg(
				pll_control_status_register_ff, h_csr, AVS_WRITEDATA,
				AVS_BYTEENABLE, `PLLCG_MSK_CSR);
			pll_multiplier_register_ff <= wr_reg(
				pll_multiplier_register_ff, h_mult, AVS_WRITEDATA,
				AVS_BYTEENABLE, `PLLCG_MSK_MULT);
			input_prescaler_register_ff <= wr_reg(
				input_prescaler_register_ff, h_pre, AVS_WRITEDATA,
				AVS_BYTEENABLE, `PLLCG_MSK_DIV);
			core_divider_register_ff <= wr_reg(
				core_divider_register_ff, h_core, AVS_WRITEDATA,
				AVS_BYTEENABLE, `PLLCG_MSK_DIV);
			peripheral_divider_register_ff <= wr_reg(
				peripheral_divider_register_ff, h_pbus, AVS_WRITEDATA,
				AVS_BYTEENABLE, `PLLCG_MSK_DIV);
			memory_divider_register_ff <= wr_reg(
				memory_divider_register_ff, h_mem, AVS_WRITEDATA,
				AVS_BYTEENABLE, `PLLCG_MSK_DIV);
			oscillator_divider_register_ff <= wr_reg(
				oscillator_divider_register_ff, h_osc, AVS_WRITEDATA,
				AVS_BYTEENABLE, `PLLCG_MSK_DIV);
			memory_interface_global_control_ff <= wr_reg(
				memory_interface_global_control_ff, h_gbl, AVS_WRITEDATA,
				AVS_BYTEENABLE, `PLLCG_MSK_GBL);
			device_configuration_register_ff <= wr_reg(
				device_configuration_register_ff, h_dev, AVS_WRITEDATA,
				AVS_BYTEENABLE, `PLLCG_MSK_DEVICE_CONFIGURATION_REGISTER);
		end
	end

	////////////////////////////////////////////////////////////////////
	// input clock edge and stable counter
	assign ref_edge = REF_IN && !ref_q_ff;
	assign nxt_stable_cnt = (ref_edge && !stable_ff) ?
		stable_cnt_ff + 16'h0001 : stable_cnt_ff;
	assign nxt_stable = stable_ff ||
		(nxt_stable_cnt >= 16'(STABLE_EDGES));

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			ref_q_ff      <= 1'b0;
			stable_cnt_ff <= 16'h0000;
			stable_ff     <= 1'b0;
		end
		else
		begin
			ref_q_ff      <= REF_IN;
			stable_cnt_ff <= nxt_stable_cnt;
			stable_ff     <= nxt_stable;
		end
	end

	////////////////////////////////////////////////////////////////////
	// dividers
	pllcg_div_if dv[5] ();

	for (genvar i = 0; i < 5; i++)
	begin : g_div
		pllcg_div u_div
		(
			.bus (dv[i]),
			.CLK (CLK),
			.RST (RST)
		);
	end

	assign dv[pllcg_pkg::PLLCG_DV_PRE].tick_in = ref_edge;
	assign dv[pllcg_pkg::PLLCG_DV_PRE].en =
		input_prescaler_register_ff[`PLLCG_DIVEN_BIT];
	assign dv[pllcg_pkg::PLLCG_DV_PRE].ratio =
		input_prescaler_register_ff[`PLLCG_RATIO_W-1:0];
	assign dv[pllcg_pkg::PLLCG_DV_OSC].tick_in = ref_edge;
	assign dv[pllcg_pkg::PLLCG_DV_OSC].en =
		oscillator_divider_register_ff[`PLLCG_DIVEN_BIT];
	assign dv[pllcg_pkg::PLLCG_DV_OSC].ratio =
		oscillator_divider_register_ff[`PLLCG_RATIO_W-1:0];
	// core, peripheral and memory take the very same tick
	assign dv[pllcg_pkg::PLLCG_DV_CORE].tick_in = hf_tick;
	assign dv[pllcg_pkg::PLLCG_DV_PBUS].tick_in = hf_tick;
	assign dv[pllcg_pkg::PLLCG_DV_MEM].tick_in  = hf_tick;
	assign dv[pllcg_pkg::PLLCG_DV_CORE].en =
		core_divider_register_ff[`PLLCG_DIVEN_BIT];
	assign dv[pllcg_pkg::PLLCG_DV_CORE].ratio =
		core_divider_register_ff[`PLLCG_RATIO_W-1:0];
	assign dv[pllcg_pkg::PLLCG_DV_PBUS].en =
		peripheral_divider_register_ff[`PLLCG_DIVEN_BIT];
	assign dv[pllcg_pkg::PLLCG_DV_PBUS].ratio =
		peripheral_divider_register_ff[`PLLCG_RATIO_W-1:0];
	assign dv[pllcg_pkg::PLLCG_DV_MEM].en =
		memory_divider_register_ff[`PLLCG_DIVEN_BIT];
	assign dv[pllcg_pkg::PLLCG_DV_MEM].ratio =
		memory_divider_register_ff[`PLLCG_RATIO_W-1:0];

	////////////////////////////////////////////////////////////////////
	// pll model: rate accumulator, multiplier ticks per prescaled tick
	assign pll_run  = !pll_control_status_register_ff[`PLLCG_RSTC_BIT] &&
		!pll_control_status_register_ff[`PLLCG_PWRDN_BIT];
	assign path_pll = pll_control_status_register_ff[`PLLCG_PATH_BIT];
	assign pre_tick = dv[pllcg_pkg::PLLCG_DV_PRE].tick_out;
	assign acc_add  = pre_tick ?
		`PLLCG_ACC_W'(pll_multiplier_register_ff[4:0]) : '0;
	// at most one tick per cycle; faster settings are out of range
	assign nxt_acc  = !pll_run ? '0 :
		acc_ff + acc_add - `PLLCG_ACC_W'(acc_ff != '0);
	assign nxt_pll_tick = pll_run && (acc_ff != '0);
	assign hf_tick  = path_pll ? pll_tick_ff : ref_edge;

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			acc_ff      <= '0;
			pll_tick_ff <= 1'b0;
		end
		else
		begin
			acc_ff      <= nxt_acc;
			pll_tick_ff <= nxt_pll_tick;
		end
	end

	////////////////////////////////////////////////////////////////////
	// output pins
	assign nxt_ck2 = dv[pllcg_pkg::PLLCG_DV_PBUS].tick_out &&
		peripheral_divider_register_ff[`PLLCG_DIVEN_BIT] &&
		memory_interface_global_control_ff[`PLLCG_SECOND_CLOCK_OUT_ENABLE_BIT];
	assign nxt_mout = memory_interface_global_control_ff[`PLLCG_MEMEN_BIT]
		&& (device_configuration_register_ff[`PLLCG_MSRC_BIT] ?
		MEM_CLK_IN : dv[pllcg_pkg::PLLCG_DV_MEM].tick_out);

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			aux_ff   <= 1'b0;
			hf_ff    <= 1'b0;
			core_ff  <= 1'b0;
			pbus_ff  <= 1'b0;
			memif_ff <= 1'b0;
			ck2_ff   <= 1'b0;
			ck3_ff   <= 1'b0;
			mout_ff  <= 1'b0;
		end
		else
		begin
			aux_ff   <= REF_IN;
			hf_ff    <= hf_tick;
			core_ff  <= dv[pllcg_pkg::PLLCG_DV_CORE].tick_out;
			pbus_ff  <= dv[pllcg_pkg::PLLCG_DV_PBUS].tick_out;
			memif_ff <= dv[pllcg_pkg::PLLCG_DV_MEM].tick_out;
			ck2_ff   <= nxt_ck2;
			ck3_ff   <= dv[pllcg_pkg::PLLCG_DV_OSC].tick_out &&
				oscillator_divider_register_ff[`PLLCG_DIVEN_BIT];
			mout_ff  <= nxt_mout;
		end
	end

	assign AVS_READDATA    = readdata_ff;
	assign AVS_WAITREQUEST = wait_ff;
	assign AUDIO_AUX_CLK   = aux_ff;
	assign HF_REF_TICK     = hf_ff;
	assign CORE_CLK        = core_ff;
	assign PBUS_CLK        = pbus_ff;
	assign MEM_IF_CLK      = memif_ff;
	assign SECOND_CLK_OUT  = ck2_ff;
	assign THIRD_CLK_OUT   = ck3_ff;
	assign MEM_CLK_OUT     = mout_ff;
endmodule

/* tb/pllcg_sva.sv */
`timescale 1ns/1ps
module pllcg_sva
#(
	parameter int STABLE_EDGES = 256
)
(
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        REF_IN,
	input wire logic        MEM_CLK_IN,
	input wire logic [5:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0]  AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        AUDIO_AUX_CLK,
	input wire logic        HF_REF_TICK,
	input wire logic        CORE_CLK,
	input wire logic        PBUS_CLK,
	input wire logic        MEM_IF_CLK,
	input wire logic        SECOND_CLK_OUT,
	input wire logic        THIRD_CLK_OUT,
	input wire logic        MEM_CLK_OUT
);
	logic p15_ff, o15_ff, g3_ff, g5_ff, src_ff;
	wire  acc_wr = AVS_WRITE && !AVS_WAITREQUEST;
	wire  lo     = acc_wr && AVS_BYTEENABLE[0];
	wire  hi     = acc_wr && AVS_BYTEENABLE[1];
	wire  sec_en = g3_ff && p15_ff;
	// shadow of the gating bits, updated when a write is accepted
	always_ff @(posedge CLK or posedge RST)
		if (RST)
		begin
			{p15_ff, o15_ff, g3_ff, g5_ff, src_ff} <= 5'h1e;
		end
		else
		begin
			if (hi && AVS_ADDRESS == 6'h10) p15_ff <= AVS_WRITEDATA[15];
			if (hi && AVS_ADDRESS == 6'h18) o15_ff <= AVS_WRITEDATA[15];
			if (lo && AVS_ADDRESS == 6'h1c) g3_ff <= AVS_WRITEDATA[3];
			if (lo && AVS_ADDRESS == 6'h1c) g5_ff <= AVS_WRITEDATA[5];
			if (lo && AVS_ADDRESS == 6'h20) src_ff <= AVS_WRITEDATA[4];
		end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_quiet(e);
		!e ##1 !e ##1 !e;
	endsequence
	a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
		|=> !AVS_WAITREQUEST) else $error("request not answered in one cycle");
	a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	a_aux_copy: assert property (
		!$past(RST) |-> AUDIO_AUX_CLK == $past(REF_IN))
		else $error("aux clock is not a copy of the reference");
	a_second_src: assert property (
		SECOND_CLK_OUT |-> PBUS_CLK || $past(PBUS_CLK))
		else $error("second output pulse without peripheral pulse");
	a_second_gate: assert property (s_quiet(sec_en) |-> !SECOND_CLK_OUT)
		else $error("second output pulses while disabled");
	a_third_gate: assert property (s_quiet(o15_ff) |-> !THIRD_CLK_OUT)
		else $error("third output pulses while disabled");
	a_mem_gate: assert property (s_quiet(g5_ff) |-> !MEM_CLK_OUT)
		else $error("memory output pulses while disabled");
	a_mem_ext: assert property (
		s_quiet(!src_ff) ##0 MEM_CLK_OUT |-> $past(MEM_CLK_IN)
		|| $past(MEM_CLK_IN, 2)) else $error("memory output not from input");
	a_mem_div: assert property (
		s_quiet(src_ff) ##0 MEM_CLK_OUT |-> MEM_IF_CLK || $past(MEM_IF_CLK))
		else $error("memory output not from memory divider");
	a_core_hf: assert property (CORE_CLK |-> HF_REF_TICK
		|| $past(HF_REF_TICK) || $past(HF_REF_TICK, 2))
		else $error("core pulse without reference tick");
	a_csr_fields: assert property (
		AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 6'h00
		|-> (AVS_READDATA & 32'hffffffb4) == 32'h0)
		else $error("reserved control bits read nonzero");
	a_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST
		&& AVS_ADDRESS > 6'h20 |-> AVS_READDATA == 32'h0)
		else $error("unmapped read returned nonzero");
endmodule

/* tb/pllcg_ref_src.sv */
`timescale 1ns/1ps
module pllcg_ref_src
#(
	parameter int HALF  = 2,
	parameter int MHALF = 3
)
(
	input wire logic clk,
	output logic     ref_out,
	output logic     mem_out
);
	int   ref_cnt_ff = 0;
	int   mem_cnt_ff = 0;
	logic ref_ff     = 1'b0;
	logic mem_ff     = 1'b0;
	// free-running oscillators, slow enough to stay within limits
	always @(posedge clk)
	begin
		ref_cnt_ff <= (ref_cnt_ff == HALF - 1) ? 0 : ref_cnt_ff + 1;
		mem_cnt_ff <= (mem_cnt_ff == MHALF - 1) ? 0 : mem_cnt_ff + 1;
		if (ref_cnt_ff == HALF - 1)
			ref_ff <= !ref_ff;
		if (mem_cnt_ff == MHALF - 1)
			mem_ff <= !mem_ff;
	end
	assign ref_out = ref_ff;
	assign mem_out = mem_ff;
endmodule

/* tb/pllcg_top_tb.sv */
`timescale 1ns/1ps
module pllcg_top_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ref_in, mem_in, rd = 1'b0, wr_en = 1'b0;
	logic [5:0]  addr = 6'h00;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [3:0]  be = 4'hf;
	logic        wait_n, aux, hf, core, pbus, memif, sec, third, mout;
	int          err_total = 0;
	int          n_compared = 0;
	logic [31:0] rst_tab [1:9] = '{32'h04, 32'h8000, 32'h8000, 32'h8001,
		32'h8001, 32'h8007, 32'h28, 32'h00, 32'h00};
	wire  [7:0]  outs = {aux, hf, mout, third, sec, memif, pbus, core};
	always #50 clk = ~clk;
	pllcg_ref_src i_src (.clk(clk), .ref_out(ref_in), .mem_out(mem_in));
	pllcg_top #(.STABLE_EDGES(4)) i_dut (.CLK(clk), .RST(rst),
		.REF_IN(ref_in), .MEM_CLK_IN(mem_in), .AVS_ADDRESS(addr),
		.AVS_READ(rd), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wait_n), .AUDIO_AUX_CLK(aux), .HF_REF_TICK(hf),
		.CORE_CLK(core), .PBUS_CLK(pbus), .MEM_IF_CLK(memif),
		.SECOND_CLK_OUT(sec), .THIRD_CLK_OUT(third), .MEM_CLK_OUT(mout));
	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task acc(input logic w, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] b, output logic [31:0] r);
		addr <= a;
		wdata <= d;
		be <= b;
		wr_en <= w;
		rd <= !w;
		// only the watchdog ends a wait that never gets an answer
		do
			@(posedge clk);
		while (wait_n !== 1'b0);
		r = rdata;
		wr_en <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 4'hf, q);
	endtask
	task rd_chk(input logic [5:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0, 4'hf, q);
		check(q, exp);
	endtask
	// counts rising edges of one output and the spacing of the last two
	task meas(input int s, input int win, output int cnt, output int per);
		int last;
		logic prv;
		cnt = 0;
		per = 0;
		last = 0;
		prv = outs[s];
		for (int i = 1; i <= win; i++)
		begin
			@(posedge clk);
			if (outs[s] === 1'b1 && prv !== 1'b1)
			begin
				cnt++;
				per = i - last;
				last = i;
			end
			prv = outs[s];
		end
	endtask
	task per_is(input int s, input int exp);
		int c, p;
		// long enough to outlast a ratio change waiting for the old period
		meas(s, exp * 4 + 160, c, p);
		check(p, exp);
	endtask
	task none(input int s);
		int c, p;
		meas(s, 200, c, p);
		check(c, 0);
	endtask
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(30000 * 100);
		err_total++;
		conclude;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk(6'h00, 32'h08);
		for (int i = 1; i < 10; i++) rd_chk(6'(4 * i), rst_tab[i]);
		repeat (40) @(posedge clk);
		rd_chk(6'h00, 32'h48);
		wr(6'h00, 32'hfffffffc);
		rd_chk(6'h00, 32'h48);
		per_is(6, 4);
		per_is(7, 4);
		per_is(0, 4);
		per_is(1, 8);
		per_is(2, 8);
		per_is(3, 8);
		per_is(5, 8);
		per_is(4, 32);
		wr(6'h18, 32'h8000);
		per_is(4, 4);
		wr(6'h18, 32'h801f);
		per_is(4, 128);
		acc(1'b1, 6'h18, 32'h2, 4'h1, q);
		rd_chk(6'h18, 32'h8002);
		per_is(4, 12);
		acc(1'b1, 6'h18, 32'h2, 4'h3, q);
		none(4);
		wr(6'h1c, 32'h20);
		none(3);
		wr(6'h1c, 32'h08);
		none(5);
		wr(6'h1c, 32'h28);
		wr(6'h20, 32'h10);
		per_is(5, 6);
		wr(6'h20, 32'h00);
		wr(6'h10, 32'h8005);
		wr(6'h0c, 32'h8002);
		rd_chk(6'h10, 32'h8005);
		per_is(0, 12);
		per_is(1, 24);
		wr(6'h14, 32'h8007);
		wr(6'h08, 32'h8003);
		wr(6'h00, 32'h00);
		repeat (1875) @(posedge clk);
		wr(6'h00, 32'h01);
		per_is(2, 32);
		wr(6'h00, 32'h00);
		wr(6'h04, 32'h08);
		repeat (1875) @(posedge clk);
		wr(6'h00, 32'h01);
		per_is(2, 16);
		wr(6'h00, 32'h03);
		repeat (2) @(posedge clk);
		none(6);
		conclude;
	end
endmodule
bind pllcg_top pllcg_sva #(.STABLE_EDGES(STABLE_EDGES)) i_sva (.CLK(CLK),
	.RST(RST), .REF_IN(REF_IN), .MEM_CLK_IN(MEM_CLK_IN),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.AUDIO_AUX_CLK(AUDIO_AUX_CLK), .HF_REF_TICK(HF_REF_TICK),
	.CORE_CLK(CORE_CLK), .PBUS_CLK(PBUS_CLK), .MEM_IF_CLK(MEM_IF_CLK),
	.SECOND_CLK_OUT(SECOND_CLK_OUT), .THIRD_CLK_OUT(THIRD_CLK_OUT),
	.MEM_CLK_OUT(MEM_CLK_OUT));
